// *** logic/bmr_pkg.sv ***
// Constants and helpers shared by the burst and mode register logic.
package bmr_pkg;
	localparam logic [5:0] MODE_ADDR       = 6'h01;
	localparam logic [7:0] CFG_RESET       = 8'h04;
	localparam int         BL_POS          = 0;
	localparam int         WR_PRE_POS      = 2;
	localparam int         RD_PRE_POS      = 3;
	localparam int         WR_REC_POS      = 4;
	localparam int         POST_POS        = 7;
	localparam logic [1:0] BL_16           = 2'h0;
	localparam logic [1:0] BL_32           = 2'h1;
	localparam logic [1:0] BL_OTF          = 2'h2;
	localparam logic [1:0] BL_RSVD         = 2'h3;
	localparam logic [4:0] LEN16_LAST      = 5'h0f;
	localparam logic [4:0] LEN32_LAST      = 5'h1f;
	localparam int         TCK_PER_PRE     = 2;
	localparam logic [2:0] PRE_HALVES      = 3'(2 * TCK_PER_PRE);
	localparam logic [2:0] POST_SHORT      = 3'h1;
	localparam logic [2:0] POST_LONG       = 3'h3;
	localparam logic [2:0] POST_TOGGLES    = 3'h2;
	localparam logic [5:0] WR_REC_X16 [8]  = '{6'd6, 6'd10, 6'd16, 6'd20,
		6'd24, 6'd30, 6'd34, 6'd40};
	localparam logic [5:0] WR_REC_X8 [8]   = '{6'd6, 6'd12, 6'd16, 6'd22,
		6'd28, 6'd38, 6'd38, 6'd44};
	localparam int         PIN_W           = 27;

	typedef enum logic [1:0] {BMR_IDLE, BMR_PRE, BMR_DATA, BMR_POST} bmr_state_type;

	// Write-recovery cycles for a field code; x8 codes 5 and 6 are unconfirmed.
	function automatic logic [5:0] bmr_wr_rec(input logic [2:0] code, input logic byte_mode);
		bmr_wr_rec = byte_mode ? WR_REC_X8[code] : WR_REC_X16[code];
	endfunction
endpackage

// *** logic/bmr_seq_if.sv ***
// Signals between the burst controller and the beat address sequencer.
interface bmr_seq_if;
	logic       load;
	logic       step;
	logic [2:0] start;
	logic [4:0] addr;
	logic [4:0] count;
	modport ctrl (output load, output step, output start, input addr, input count);
	modport seq  (input load, input step, input start, output addr, output count);
endinterface

// *** logic/bmr_beat_seq.sv ***
// Beat address sequencer producing the column order of one burst.
module bmr_beat_seq (
	input  wire logic ref_clk,
	input  wire logic rst,
	bmr_seq_if.seq    sq
);
	logic [2:0] start;
	logic [4:0] count;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			start <= 3'h0;
			count <= 5'h00;
		end else if (sq.load) begin
			start <= sq.start;
			count <= 5'h00;
		end else if (sq.step) begin
			count <= count + 5'h01;
		end
	end

	// Low two column bits are always zero, so every burst starts on a four-beat boundary.
	// The low nibble wraps in its block, and the second half of a long burst
	// repeats that order in the other half.
	assign sq.addr  = {start[2] ^ count[4], 4'(count[3:0] + {start[1:0], 2'h0})}; // RULE14 RULE15 RULE16
	assign sq.count = count;
endmodule

// *** logic/bmr_top.sv ***
// Burst configuration register with set points, and read/write burst sequencing.
// Summary of operation
// RULE1: Configuration register answers at mode register address 01.
// RULE2: Burst field: 00 gives 16 beats, 01 gives 32, 10 per command.
// RULE3: In per-command mode the command's length bit picks 16 or 32 beats.
// RULE4: Bit 2 set gives a two-clock write preamble; clear is reserved.
// RULE5: Bit 3 clear gives a static read preamble, set a toggling one.
// RULE6: x16 write recovery codes map to 6,10,16,20,24,30,34,40 cycles.
// RULE7: x8 write recovery codes map to 6,12,16,22,28,38,38,44 cycles.
// RULE8: Auto-precharge starts after counting write recovery cycles past the write.
// RULE9: Bit 7 clear gives half-clock read postamble, set gives one and half.
// RULE10: Long postamble adds one rising and one falling strobe edge.
// RULE11: Each field has two set-point copies; reads return the write-selected copy.
// RULE12: Operation uses only the operate-selected copy; the other is free to change.
// RULE13: Controller programs identical burst codes into both set points.
// RULE14: Column bits 1:0 are zero, so bursts start on four-beat boundaries.
// RULE15: Sixteen-beat reads start at column 3:2 times four and wrap modulo 16.
// RULE16: Long reads start in the half chosen by column 4, then do the other.
// RULE17: Controller sends column bits 3:2 as zero on writes.
// RULE18: Writes start on a boundary of their own burst length.
// RULE19: Controller avoids reserved burst and preamble codes; device flags them.
// RULE20: After reset both copies hold the default configuration.
module bmr_top (
	input  wire logic       ref_clk,
	input  wire logic       rst,
	input  wire logic       cmd_clk,
	input  wire logic       mrw_req,
	input  wire logic       mrr_req,
	input  wire logic [5:0] mode_addr,
	input  wire logic [7:0] mode_wdata,
	input  wire logic       rd_req,
	input  wire logic       wr_req,
	input  wire logic       auto_pre,
	input  wire logic       otf_bl32,
	input  wire logic [4:2] col_addr,
	input  wire logic       setpoint_write_select,
	input  wire logic       setpoint_operate_select,
	input  wire logic       byte_mode,
	output logic      [7:0] mrr_data,
	output logic            mrr_valid,
	output logic            beat_valid,
	output logic            beat_is_read,
	output logic      [4:0] beat_addr,
	output logic            dqs_out,
	output logic            dqs_oe,
	output logic            precharge_start,
	output logic            cfg_error
);
	logic [bmr_pkg::PIN_W-1:0] pin_s1;
	logic [bmr_pkg::PIN_W-1:0] pin_s2;
	logic                      clk_d;
	logic                      rise_tick;
	logic                      half_tick;
	logic [7:0]                burst_preamble_config [2];
	logic [7:0]                act;
	logic                      is_rd;
	logic                      len32;
	logic                      ap;
	logic                      long_post;
	logic [2:0]                halves;
	logic [5:0]                wr_cnt;
	bmr_pkg::bmr_state_type    state;
	logic                      c_mrw;
	logic                      c_mrr;
	logic [5:0]                c_addr;
	logic [7:0]                c_wdata;
	logic                      c_rd;
	logic                      c_wr;
	logic                      c_ap;
	logic                      c_bl32;
	logic [2:0]                c_col;
	logic                      c_wsel;
	logic                      c_osel;
	logic                      c_byte;
	logic                      c_clk;
	logic [1:0]                burst_length_field;
	logic [2:0]                write_recovery_count;
	logic                      read_postamble_length;
	logic [4:0]                last_beat;
	logic [2:0]                burst_col;

	bmr_seq_if sq ();

	bmr_beat_seq u_seq (
		.ref_clk (ref_clk),
		.rst     (rst),
		.sq      (sq.seq)
	);

	// Every pin crosses two flops; the command is held for a whole link period.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			pin_s1 <= '0;
			pin_s2 <= '0;
			clk_d  <= 1'b0;
		end else begin
			pin_s1 <= {cmd_clk, mrw_req, mrr_req, mode_addr, mode_wdata, rd_req, wr_req,
				auto_pre, otf_bl32, col_addr, setpoint_write_select,
				setpoint_operate_select, byte_mode};
			pin_s2 <= pin_s1;
			clk_d  <= c_clk;
		end
	end

	assign {c_clk, c_mrw, c_mrr, c_addr, c_wdata, c_rd, c_wr, c_ap, c_bl32, c_col,
		c_wsel, c_osel, c_byte} = pin_s2;
	assign rise_tick = c_clk & ~clk_d;
	assign half_tick = c_clk ^ clk_d;

	// Only the operating copy steers the burst logic.
	assign act                   = burst_preamble_config[c_osel]; // RULE12
	assign burst_length_field    = act[bmr_pkg::BL_POS +: 2];
	assign write_recovery_count  = act[bmr_pkg::WR_REC_POS +: 3];
	assign read_postamble_length = act[bmr_pkg::POST_POS];
	assign last_beat             = len32 ? bmr_pkg::LEN32_LAST : bmr_pkg::LEN16_LAST;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			burst_preamble_config[0] <= bmr_pkg::CFG_RESET; // RULE20
			burst_preamble_config[1] <= bmr_pkg::CFG_RESET; // RULE20
		end else if (rise_tick && c_mrw && c_addr == bmr_pkg::MODE_ADDR) begin // RULE1
			burst_preamble_config[c_wsel] <= c_wdata; // RULE11
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			mrr_valid <= 1'b0;
			mrr_data  <= 8'h00;
		end else begin
			mrr_valid <= rise_tick & c_mrr;
			if (rise_tick && c_mrr) begin
				mrr_data <= (c_addr == bmr_pkg::MODE_ADDR) ? burst_preamble_config[c_wsel] : 8'h00; // RULE11
			end
		end
	end

	// Reserved codes leave behaviour undefined, so they are reported.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cfg_error <= 1'b0;
		end else begin
			cfg_error <= (burst_length_field == bmr_pkg::BL_RSVD) | ~act[bmr_pkg::WR_PRE_POS]; // RULE19 RULE4
		end
	end

	always_comb begin
		sq.load  = 1'b0;
		sq.step  = 1'b0;
		sq.start = c_col;
		if (state == bmr_pkg::BMR_IDLE && rise_tick && (c_rd || c_wr)) begin
			sq.load = 1'b1;
		end
		if (state == bmr_pkg::BMR_DATA && half_tick) begin
			sq.step = 1'b1;
		end
	end

	// One half tick is one beat; preamble and postamble are counted in half ticks.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state        <= bmr_pkg::BMR_IDLE;
			is_rd        <= 1'b0;
			len32        <= 1'b0;
			ap           <= 1'b0;
			long_post    <= 1'b0;
			burst_col    <= 3'h0;
			halves       <= 3'h0;
			dqs_out      <= 1'b0;
			dqs_oe       <= 1'b0;
			beat_valid   <= 1'b0;
			beat_is_read <= 1'b0;
			beat_addr    <= 5'h00;
		end else begin
			beat_valid <= 1'b0;
			case (state)
				bmr_pkg::BMR_IDLE: begin
					if (rise_tick && (c_rd || c_wr)) begin
						is_rd     <= c_rd;
						burst_col <= c_col;
						len32     <= (burst_length_field == bmr_pkg::BL_32) ||
							(burst_length_field == bmr_pkg::BL_OTF && c_bl32); // RULE2 RULE3
						ap        <= c_wr & c_ap;
						long_post <= read_postamble_length; // RULE9
						halves    <= 3'h0;
						dqs_out   <= 1'b0;
						dqs_oe    <= c_rd;
						state     <= bmr_pkg::BMR_PRE;
					end
				end
				bmr_pkg::BMR_PRE: begin
					if (half_tick) begin
						halves <= halves + 3'h1;
						if (is_rd && act[bmr_pkg::RD_PRE_POS]) begin
							dqs_out <= ~dqs_out; // RULE5
						end
						if (halves == bmr_pkg::PRE_HALVES - 3'h1) begin // RULE4
							state <= bmr_pkg::BMR_DATA;
						end
					end
				end
				bmr_pkg::BMR_DATA: begin
					if (half_tick) begin
						beat_valid   <= 1'b1;
						beat_is_read <= is_rd;
						beat_addr    <= sq.addr; // RULE15 RULE16 RULE18
						if (is_rd) begin
							dqs_out <= ~dqs_out;
						end
						if (sq.count == last_beat) begin
							halves <= 3'h0;
							state  <= bmr_pkg::BMR_POST;
						end
					end
				end
				bmr_pkg::BMR_POST: begin
					if (half_tick) begin
						halves <= halves + 3'h1;
						if (is_rd && long_post && halves < bmr_pkg::POST_TOGGLES) begin
							dqs_out <= ~dqs_out; // RULE10
						end
						if (halves == (long_post && is_rd ? bmr_pkg::POST_LONG : bmr_pkg::POST_SHORT) - 3'h1) begin // RULE9
							dqs_oe <= 1'b0;
							dqs_out <= 1'b0;
							state  <= bmr_pkg::BMR_IDLE;
						end
					end
				end
				default: begin
					state <= bmr_pkg::BMR_IDLE;
				end
			endcase
		end
	end

	// The recovery count is taken when the write data ends, in link clock cycles.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			wr_cnt          <= 6'h00;
			precharge_start <= 1'b0;
		end else begin
			precharge_start <= 1'b0;
			if (state == bmr_pkg::BMR_DATA && half_tick && sq.count == last_beat && ap) begin
				wr_cnt <= bmr_pkg::bmr_wr_rec(write_recovery_count, c_byte); // RULE6 RULE7 RULE8
			end else if (rise_tick && wr_cnt != 6'h00) begin
				wr_cnt          <= wr_cnt - 6'h01;
				precharge_start <= (wr_cnt == 6'h01); // RULE8
			end
		end
	end

	logic [5:0] beats_seen;
	logic [2:0] post_edges;
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			beats_seen <= 6'h00;
			post_edges <= 3'h0;
		end else begin
			beats_seen <= (state == bmr_pkg::BMR_IDLE) ? 6'h00 : beats_seen + 6'(beat_valid);
			post_edges <= (state != bmr_pkg::BMR_POST) ? 3'h0 : post_edges + 3'($changed(dqs_out));
		end
	end

	mrr_selects_a: assert property (@(posedge ref_clk) disable iff (rst) // RULE11
		rise_tick && c_mrr && c_addr == bmr_pkg::MODE_ADDR |=>
		mrr_valid && mrr_data == burst_preamble_config[$past(c_wsel)])
		else $error("mode read did not return the write-selected copy");
	other_addr_a: assert property (@(posedge ref_clk) disable iff (rst) // RULE1
		rise_tick && c_mrw && c_addr != bmr_pkg::MODE_ADDR |=>
		$stable(burst_preamble_config[0]) && $stable(burst_preamble_config[1]))
		else $error("write to another address changed the configuration");
	burst_count_a: assert property (@(posedge ref_clk) disable iff (rst) // RULE2 RULE3
		state == bmr_pkg::BMR_POST && $past(state) == bmr_pkg::BMR_DATA |=>
		beats_seen == (len32 ? 6'd32 : 6'd16))
		else $error("burst delivered the wrong number of beats");
	static_pre_a: assert property (@(posedge ref_clk) disable iff (rst) // RULE5
		state == bmr_pkg::BMR_PRE && is_rd && !act[bmr_pkg::RD_PRE_POS] |-> !dqs_out)
		else $error("static read preamble toggled");
	pre_length_a: assert property (@(posedge ref_clk) disable iff (rst) // RULE4
		$rose(state == bmr_pkg::BMR_DATA) |-> halves == bmr_pkg::PRE_HALVES)
		else $error("preamble length wrong");
	seq_wrap_a: assert property (@(posedge ref_clk) disable iff (rst) // RULE15
		sq.step |=> sq.addr[3:0] == 4'($past(sq.addr[3:0]) + 4'h1))
		else $error("beat order did not wrap modulo sixteen");
	half_swap_a: assert property (@(posedge ref_clk) disable iff (rst) // RULE16 RULE14
		state == bmr_pkg::BMR_DATA |-> sq.addr[4] == (burst_col[2] ^ sq.count[4]) &&
		sq.addr[1:0] == sq.count[1:0])
		else $error("long burst half order wrong");
	long_post_a: assert property (@(posedge ref_clk) disable iff (rst) // RULE10
		$fell(state == bmr_pkg::BMR_POST) && is_rd && long_post |->
		$past(post_edges) + 3'($past(dqs_out) != 1'b0) >= bmr_pkg::POST_TOGGLES)
		else $error("long postamble lacked its extra strobe edges");
	precharge_a: assert property (@(posedge ref_clk) disable iff (rst) // RULE8
		precharge_start |-> $past(wr_cnt) == 6'h01 && wr_cnt == 6'h00)
		else $error("precharge started before recovery elapsed");
	default_cfg_a: assert property (@(posedge ref_clk) disable iff (rst) // RULE20
		$fell(rst) |-> burst_preamble_config[0] == bmr_pkg::CFG_RESET)
		else $error("configuration not at default after reset");
endmodule

// *** verif/bmr_ctl_model.sv ***
// Memory controller model that drives the link clock and commands into the burst block.
module bmr_ctl_model (
	input  wire logic       ref_clk,
	output logic            cmd_clk,
	output logic            mrw_req,
	output logic            mrr_req,
	output logic      [5:0] mode_addr,
	output logic      [7:0] mode_wdata,
	output logic            rd_req,
	output logic            wr_req,
	output logic            auto_pre,
	output logic            otf_bl32,
	output logic      [4:2] col_addr
);
	timeunit 1ns;
	timeprecision 1ns;

	initial begin
		cmd_clk = 1'b0;
		{mrw_req, mrr_req, rd_req, wr_req, auto_pre, otf_bl32} = 6'h00;
		mode_addr = 6'h00;
		mode_wdata = 8'h00;
		col_addr = 3'h0;
	end

	// The link clock runs only inside a frame; after the first period requests and auto_pre drop to zero and the other lines show the inverse of the value passed in.
	task automatic issue(input logic [3:0] req, input logic [5:0] addr, input logic [7:0] data,
		input logic otf, input logic [4:2] col, input logic ap, input int periods);
		@(posedge ref_clk);
		{mrw_req, mrr_req, rd_req, wr_req} <= req;
		mode_addr <= addr;
		mode_wdata <= data;
		otf_bl32 <= otf;
		col_addr <= req[0] ? 3'h0 : col;
		auto_pre <= ap;
		for (int p = 0; p < periods; p++) begin
			repeat (4) @(posedge ref_clk);
			cmd_clk <= 1'b1;
			repeat (4) @(posedge ref_clk);
			cmd_clk <= 1'b0;
			if (p == 0) begin
				{mrw_req, mrr_req, rd_req, wr_req} <= 4'h0;
				mode_addr <= ~addr;
				mode_wdata <= ~data;
				col_addr <= ~col;
				otf_bl32 <= ~otf;
				auto_pre <= 1'b0;
			end
		end
	endtask
endmodule

// *** verif/tb.sv ***
// Self-checking bench for the burst configuration and beat ordering block.
`define CHK(what, exp, got) begin tests_run++; if ((got) !== (exp)) begin errors++; \
	$display("wrong value %s exp %0h got %0h", what, exp, got); end end

module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic       ref_clk;
	logic       rst;
	logic       cmd_clk, mrw_req, mrr_req, rd_req, wr_req, auto_pre, otf_bl32;
	logic [5:0] mode_addr;
	logic [7:0] mode_wdata;
	logic [4:2] col_addr;
	logic       setpoint_write_select, setpoint_operate_select, byte_mode;
	logic [7:0] mrr_data;
	logic       mrr_valid, beat_valid, beat_is_read, dqs_out, dqs_oe;
	logic [4:0] beat_addr;
	logic       precharge_start, cfg_error;
	logic       got_beat, prev_dqs, prev_clk;
	logic [7:0] rd_val;
	logic [5:0] beats[$];
	int         errors = 0, tests_run = 0, cycles = 0;
	int         pre_tog, post_tog, rise_cnt, rises, pre_s, post_s;
	int         rec16[8] = '{6, 10, 16, 20, 24, 30, 34, 40};

	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end

	bmr_top u_dut (.ref_clk(ref_clk), .rst(rst), .cmd_clk(cmd_clk), .mrw_req(mrw_req),
		.mrr_req(mrr_req), .mode_addr(mode_addr), .mode_wdata(mode_wdata), .rd_req(rd_req),
		.wr_req(wr_req), .auto_pre(auto_pre), .otf_bl32(otf_bl32), .col_addr(col_addr),
		.setpoint_write_select(setpoint_write_select),
		.setpoint_operate_select(setpoint_operate_select), .byte_mode(byte_mode),
		.mrr_data(mrr_data), .mrr_valid(mrr_valid), .beat_valid(beat_valid),
		.beat_is_read(beat_is_read), .beat_addr(beat_addr), .dqs_out(dqs_out), .dqs_oe(dqs_oe),
		.precharge_start(precharge_start), .cfg_error(cfg_error));

	bmr_ctl_model u_ctl (.ref_clk(ref_clk), .cmd_clk(cmd_clk), .mrw_req(mrw_req),
		.mrr_req(mrr_req), .mode_addr(mode_addr), .mode_wdata(mode_wdata), .rd_req(rd_req),
		.wr_req(wr_req), .auto_pre(auto_pre), .otf_bl32(otf_bl32), .col_addr(col_addr));

	task automatic results();
		if (errors == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			results();
		end
	end

	// Postamble strobe edges and link rises are counted from the last beat, so latency offsets cancel.
	always @(posedge ref_clk) begin
		prev_dqs <= dqs_out;
		prev_clk <= cmd_clk;
		if (mrr_valid === 1'b1) rd_val <= mrr_data;
		if (beat_valid === 1'b1) begin
			beats.push_back({beat_is_read, beat_addr});
			got_beat <= 1'b1;
			post_tog <= 0;
			rise_cnt <= 0;
		end else begin
			if (dqs_oe === 1'b1 && dqs_out !== prev_dqs) begin
				if (got_beat) post_tog <= post_tog + 1;
				else pre_tog <= pre_tog + 1;
			end
			if (cmd_clk && !prev_clk) rise_cnt <= rise_cnt + 1;
		end
		if (precharge_start === 1'b1) rises <= rise_cnt;
	end

	task automatic cfg(input logic sp, input logic [5:0] addr, input logic [7:0] data);
		@(posedge ref_clk);
		setpoint_write_select <= sp;
		u_ctl.issue(4'h8, addr, data, 1'b0, 3'h0, 1'b0, 1);
	endtask

	task automatic both(input logic [7:0] data);
		cfg(1'b0, 6'h01, data);
		cfg(1'b1, 6'h01, data);
		repeat (3) @(posedge ref_clk);
	endtask

	task automatic mrr(input logic sp, input logic [5:0] addr, input logic [7:0] exp);
		@(posedge ref_clk);
		setpoint_write_select <= sp;
		rd_val = 8'h5a;
		u_ctl.issue(4'h4, addr, 8'h00, 1'b0, 3'h0, 1'b0, 1);
		repeat (3) @(posedge ref_clk);
		`CHK("mode read", exp, rd_val)
	endtask

	task automatic burst(input logic rd, input logic [4:2] col, input logic otf,
		input int len, input int periods);
		logic [5:0] exp;
		beats.delete();
		pre_tog = 0;
		post_tog = 0;
		got_beat = 1'b0;
		rises = -1;
		u_ctl.issue(rd ? 4'h2 : 4'h1, 6'h00, 8'h00, otf, col, !rd, periods);
		`CHK("beat count", len, beats.size())
		`CHK("strobe released", 1'b0, dqs_oe)
		for (int i = 0; i < len; i++) begin
			exp = {rd, rd ? {col[4] ^ i[4], 4'(i[3:0] + {col[3:2], 2'b00})} : 5'(i)};
			`CHK("beat order", exp, beats[i])
		end
	endtask

	initial begin
		rst = 1'b1;
		{setpoint_write_select, setpoint_operate_select, byte_mode} = 3'h0;
		{got_beat, prev_dqs, prev_clk} = 3'h0;
		rd_val = 8'h00;
		repeat (20) @(posedge ref_clk);
		rst <= 1'b0;
		mrr(1'b0, 6'h01, 8'h04);
		mrr(1'b1, 6'h01, 8'h04);
		cfg(1'b0, 6'h01, 8'h04);
		cfg(1'b1, 6'h01, 8'h84);
		cfg(1'b1, 6'h02, 8'hff);
		mrr(1'b1, 6'h01, 8'h84);
		mrr(1'b0, 6'h01, 8'h04);
		mrr(1'b0, 6'h02, 8'h00);
		burst(1'b1, 3'h0, 1'b0, 16, 14);
		post_s = post_tog;
		pre_s = pre_tog;
		setpoint_operate_select <= 1'b1;
		burst(1'b1, 3'h0, 1'b0, 16, 14);
		`CHK("postamble edges", post_s + 2, post_tog)
		setpoint_operate_select <= 1'b0;
		both(8'h04);
		for (int c = 0; c < 8; c++) burst(1'b1, 3'(c), 1'b0, 16, 14);
		both(8'h05);
		for (int c = 0; c < 8; c += 3) burst(1'b1, 3'(c), 1'b0, 32, 22);
		burst(1'b0, 3'h7, 1'b0, 32, 40);
		`CHK("write recovery", 6, rises)
		both(8'h06);
		burst(1'b1, 3'h5, 1'b0, 16, 14);
		burst(1'b1, 3'h6, 1'b1, 32, 22);
		both(8'h0c);
		burst(1'b1, 3'h0, 1'b0, 16, 14);
		`CHK("static preamble", 0, pre_s)
		`CHK("toggle preamble", 4, pre_tog)
		for (int code = 0; code < 8; code++) begin
			both({1'b0, 3'(code), 4'h4});
			burst(1'b0, 3'h7, 1'b0, 16, 60);
			`CHK("write recovery", rec16[code], rises)
		end
		byte_mode <= 1'b1;
		both(8'h14);
		burst(1'b0, 3'h0, 1'b0, 16, 60);
		`CHK("byte recovery", 12, rises)
		both(8'h74);
		burst(1'b0, 3'h0, 1'b0, 16, 60);
		`CHK("byte recovery", 44, rises)
		both(8'h07);
		`CHK("config error", 1'b1, cfg_error)
		both(8'h00);
		`CHK("config error", 1'b1, cfg_error)
		both(8'h04);
		`CHK("config error", 1'b0, cfg_error)
		results();
	end
endmodule
